// ===== tcc_pkg.sv
// package: register map, field layout and encodings of the timer block
package tcc_pkg;

  localparam int CNT_W    = 16;
  localparam int NUM_CH   = 4;
  localparam int DT_W     = 8;
  localparam int ADDR_W   = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CNT    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TOP    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IEN    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DTIME  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CHCFG0 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_CHVAL0 = 8'h30;
  localparam logic [ADDR_W-1:0] REG_CHCAP0 = 8'h40;
  localparam logic [ADDR_W-1:0] CH_STRIDE  = 8'h04;

  // ----------------------------------------------------------------
  // ctrl fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_EVCNT = 1;
  localparam int CTRL_DTEN  = 2;
  localparam int CTRL_W     = 3;

  // channel config: [1:0] mode, [3:2] capture edge, [4] input select
  localparam int CFG_W       = 5;
  localparam int CFG_EDGE_LO = 2;
  localparam int CFG_SRC     = 4;

  // status bits: [3:0] channel events, [4] overflow
  localparam int ST_W   = 5;
  localparam int ST_OVF = 4;

  localparam logic [CNT_W-1:0] TOP_RST = 16'hFFFF;
  localparam logic [DT_W-1:0]  DT_RST  = 8'h00;
  localparam logic [31:0]      RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCC_MODE_OFF     = 2'b00,
    TCC_MODE_CAPTURE = 2'b01,
    TCC_MODE_COMPARE = 2'b10,
    TCC_MODE_PWM     = 2'b11
  } tcc_mode_t;

  typedef enum logic [1:0] {
    TCC_EDGE_RISE = 2'b00,
    TCC_EDGE_FALL = 2'b01,
    TCC_EDGE_BOTH = 2'b10,
    TCC_EDGE_NONE = 2'b11
  } tcc_edge_t;

endpackage

// ===== tcc_deadtime.sv
// module: dead-time insertion for one complementary output pair
module tcc_deadtime
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // control
  input  wire logic            en,
  input  wire logic [DT_W-1:0] dtime,
  input  wire logic            din,
  // outputs
  output logic                 out_hi,
  output logic                 out_lo
);

  logic [DT_W-1:0] cnt;
  logic            last;
  wire             edge_seen = (din != last);
  wire             settled   = (cnt == DT_RST);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt    <= DT_RST;
      last   <= 1'b0;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else begin
      last <= din;
      if (!en) begin
        cnt    <= DT_RST;
        out_hi <= din;
        out_lo <= ~din;
      end else if (edge_seen) begin
        // both sides off while the gap runs, so the pair never overlaps
        cnt    <= dtime;
        out_hi <= (dtime == DT_RST) ? din : 1'b0;
        out_lo <= (dtime == DT_RST) ? ~din : 1'b0;
      end else if (!settled) begin
        cnt <= cnt - 1'b1;
      end else begin
        out_hi <= din;
        out_lo <= ~din;
      end
    end
  end

endmodule

// ===== tcc_timer.sv
// module: 16-bit timer with capture, compare and pwm channels on apb
// ----------------------------------------------------------------
// Overview of operation
// R1: the counter core is sixteen bits wide.
// R2: up to four channels, each able to capture and compare.
// R3: each channel selects one mode: capture, compare or pwm.
// R4: capture latches the counter into a buffer on the chosen input edge.
// R5: compare drives the channel output from counter versus threshold.
// R6: pwm waveform follows successive compare values written by software.
// R7: dead-time insertion exists on the first instance only.
// R8: counter can count events instead of clocks; pwm outputs generated.
// R9: overflow and channel events pulse trigger lines to the event network.
// R10: counter wraps to zero after its top and flags overflow then.
// R11: every capture or compare match sets a channel status flag.
// ----------------------------------------------------------------
module tcc_timer
  import tcc_pkg::*;
#(
  parameter bit HAS_DTI = 1'b1
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins and event inputs
  input  wire logic [NUM_CH-1:0] cc_in,
  input  wire logic [NUM_CH-1:0] event_routing_network_in,
  input  wire logic              count_in,
  // channel outputs
  output logic      [NUM_CH-1:0] cc_out,
  output logic      [NUM_CH-1:0] cc_out_n,
  // triggers and interrupt
  output logic      [ST_W-1:0]   event_routing_network_out,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  top;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   ien;
  logic [DT_W-1:0]   dtime;
  logic [CFG_W-1:0]  chcfg [NUM_CH];
  logic [CNT_W-1:0]  chval [NUM_CH];
  logic [CNT_W-1:0]  chbuf [NUM_CH];
  logic [CNT_W-1:0]  chcap [NUM_CH];
  logic [NUM_CH-1:0] cmp_lvl;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] cc_s1, cc_s2, cc_s3;
  logic [NUM_CH-1:0] ev_s1, ev_s2, ev_s3;
  logic              ci_s1, ci_s2, ci_s3;
  // stage three only keeps the previous sample for the edge detectors

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cc_s1 <= '0;
      cc_s2 <= '0;
      cc_s3 <= '0;
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
      ci_s1 <= 1'b0;
      ci_s2 <= 1'b0;
      ci_s3 <= 1'b0;
    end else begin
      cc_s1 <= cc_in;
      cc_s2 <= cc_s1;
      cc_s3 <= cc_s2;
      ev_s1 <= event_routing_network_in;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      ci_s1 <= count_in;
      ci_s2 <= ci_s1;
      ci_s3 <= ci_s2;
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic prev);
    case (sel)
      TCC_EDGE_RISE: edge_hit = now & ~prev;
      TCC_EDGE_FALL: edge_hit = ~now & prev;
      TCC_EDGE_BOTH: edge_hit = now ^ prev;
      default:       edge_hit = 1'b0;
    endcase
  endfunction

  // each channel bank is NUM_CH aligned words; the banks sit back to back, and only 0x1C before them stays unmapped
  function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off     = a - base;
    in_bank = (a >= base) && (off < NUM_CH * CH_STRIDE) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] bank_idx(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off      = a - base;
    bank_idx = off[3:2];
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       wr_en   = psel & penable & pwrite;
  wire       acc_en  = psel & penable;
  wire       is_cfg  = in_bank(paddr, REG_CHCFG0);
  wire       is_val  = in_bank(paddr, REG_CHVAL0);
  wire       is_cap  = in_bank(paddr, REG_CHCAP0);
  wire [1:0] cfg_idx = bank_idx(paddr, REG_CHCFG0);
  wire [1:0] val_idx = bank_idx(paddr, REG_CHVAL0);
  wire [1:0] cap_idx = bank_idx(paddr, REG_CHCAP0);
  wire       mapped  = (paddr == REG_CTRL) || (paddr == REG_CNT) || (paddr == REG_TOP)
                       || (paddr == REG_STATUS) || (paddr == REG_CLEAR)
                       || (paddr == REG_IEN) || (paddr == REG_DTIME)
                       || is_cfg || is_val || is_cap;
  wire       wr_clr  = wr_en && mapped && (paddr == REG_CLEAR);
  wire       wr_cnt  = wr_en && mapped && (paddr == REG_CNT);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RD_ZERO;
    if (paddr == REG_CTRL)        rd_mux[CTRL_W-1:0] = ctrl;
    else if (paddr == REG_CNT)    rd_mux[CNT_W-1:0]  = cnt;
    else if (paddr == REG_TOP)    rd_mux[CNT_W-1:0]  = top;
    else if (paddr == REG_STATUS) rd_mux[ST_W-1:0]   = status;
    else if (paddr == REG_IEN)    rd_mux[ST_W-1:0]   = ien;
    else if (paddr == REG_DTIME)  rd_mux[DT_W-1:0]   = HAS_DTI ? dtime : DT_RST;
    else if (is_cfg)              rd_mux[CFG_W-1:0]  = chcfg[cfg_idx];
    else if (is_val)              rd_mux[CNT_W-1:0]  = chval[val_idx];
    else if (is_cap)              rd_mux[CNT_W-1:0]  = chcap[cap_idx];
  end

  // single wait-free access phase; unmapped addresses answer with pslverr
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata  <= RD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : RD_ZERO;
    end
  end

  wire acc_done = acc_en & pready;

  // status and capture words have no write path; bus writes to them are dropped

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl  <= '0;
      top   <= TOP_RST;
      ien   <= '0;
      dtime <= DT_RST;
    end else if (acc_done & pwrite & mapped) begin
      if (paddr == REG_CTRL)  ctrl  <= pwdata[CTRL_W-1:0];
      if (paddr == REG_TOP)   top   <= pwdata[CNT_W-1:0];
      if (paddr == REG_IEN)   ien   <= pwdata[ST_W-1:0];
      if (paddr == REG_DTIME) dtime <= pwdata[DT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire tick     = ctrl[CTRL_EVCNT] ? (ci_s2 & ~ci_s3) : 1'b1; // R8
  wire step     = ctrl[CTRL_RUN] & tick;
  wire at_top   = (cnt == top);
  wire overflow = step & at_top;                               // R10

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= '0;
    // a bus write outranks counting so a preload never races a step
    end else if (wr_cnt & acc_done) begin
      cnt <= pwdata[CNT_W-1:0];
    end else if (step) begin
      cnt <= at_top ? '0 : cnt + 1'b1;                         // R1 R10
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] ch_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch                  // R2
      wire [1:0] mode  = chcfg[g][1:0];
      wire [1:0] esel  = chcfg[g][CFG_EDGE_LO +: 2];
      wire       src   = chcfg[g][CFG_SRC];
      wire       now   = src ? ev_s2[g] : cc_s2[g];
      wire       prev  = src ? ev_s3[g] : cc_s3[g];
      wire       cap_h = (mode == TCC_MODE_CAPTURE) && edge_hit(esel, now, prev);
      wire       match = ctrl[CTRL_RUN] && (cnt == chval[g])
                         && ((mode == TCC_MODE_COMPARE) || (mode == TCC_MODE_PWM));
      wire       wr_cf = acc_done && wr_en && is_cfg && (cfg_idx == g);
      wire       wr_vl = acc_done && wr_en && is_val && (val_idx == g);

      assign ch_evt[g] = cap_h | match;                        // R11

      always_ff @(posedge clk) begin
        if (!nrst) begin
          chcfg[g]   <= '0;
          chval[g]   <= '0;
          chbuf[g]   <= '0;
          chcap[g]   <= '0;
          cmp_lvl[g] <= 1'b0;
        end else begin
          if (wr_cf) chcfg[g] <= pwdata[CFG_W-1:0];            // R3
          if (wr_vl) chbuf[g] <= pwdata[CNT_W-1:0];
          // pwm reloads its threshold at wrap so each period is glitch free
          if (mode == TCC_MODE_PWM) begin
            if (overflow) chval[g] <= chbuf[g];                // R6
          end else if (wr_vl) begin
            chval[g] <= pwdata[CNT_W-1:0];
          end
          if (cap_h) chcap[g] <= cnt;                          // R4
          // pins lag the counter by three cycles: this level, the dead-time stage, then the pin register
          case (mode)
            TCC_MODE_COMPARE: cmp_lvl[g] <= (cnt >= chval[g]); // R5
            TCC_MODE_PWM:     cmp_lvl[g] <= (cnt < chval[g]);  // R6 R8
            default:          cmp_lvl[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs and dead time
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] dt_hi, dt_lo;
  // without dead time the pair stage passes the level and its inverse straight on
  wire               dt_on = HAS_DTI & ctrl[CTRL_DTEN];        // R7

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_dt
      tcc_deadtime u_dt (
        .clk    (clk),
        .nrst   (nrst),
        .en     (dt_on),
        .dtime  (dtime),
        .din    (cmp_lvl[g]),
        .out_hi (dt_hi[g]),
        .out_lo (dt_lo[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status, interrupt and triggers
  // ----------------------------------------------------------------
  wire [ST_W-1:0] raw_evt     = {overflow, ch_evt};
  wire [ST_W-1:0] clr_msk     = wr_clr & acc_done ? pwdata[ST_W-1:0] : '0;
  // a new event outranks a clear arriving in the same cycle
  wire [ST_W-1:0] next_status = (status & ~clr_msk) | raw_evt;

  // irq follows the new status word so it never lags a fresh event
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;                                   // R11
      irq    <= |(next_status & ien);
    end
  end

  // ----------------------------------------------------------------
  // pin and trigger outputs
  // ----------------------------------------------------------------
  // triggers are one-cycle pulses except a compare match, held while the event count rests on it; catch them on this clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_routing_network_out <= '0;
      cc_out                    <= '0;
      cc_out_n                  <= '0;
    end else begin
      event_routing_network_out <= raw_evt;                    // R9
      cc_out                    <= dt_hi;
      cc_out_n                  <= dt_lo;                      // R7
    end
  end

endmodule

// ===== tcc_timer_checker.sv
// port-level assertions for the timer block
module tcc_timer_checker
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // outputs
  input wire logic [NUM_CH-1:0] cc_out,
  input wire logic [NUM_CH-1:0] cc_out_n,
  input wire logic [ST_W-1:0]   event_routing_network_out,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire setup = psel && !penable;
  // gap at 0x1C and everything past the last capture word
  wire bad = (paddr[1:0] != 2'h0) || (paddr > 8'h4C) || (paddr == 8'h1C);
  a_ready_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_bad: assert property (setup && bad |=> pslverr) else $error("bad address taken");
  a_err_good: assert property (setup && !bad |=> !pslverr) else $error("good address refused");
  a_rdata_idle: assert property (!pready |-> prdata == RD_ZERO) else $error("data outside access");
  a_clear_rzero: assert property (setup && !pwrite && paddr == REG_CLEAR |=> prdata == RD_ZERO)
    else $error("clear register readable");
  a_pair_apart: assert property ((cc_out & cc_out_n) == 4'h0) else $error("pair overlap");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> irq == 1'b0 && cc_out == 4'h0
    && event_routing_network_out == 5'h00) else $error("outputs active in reset");
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_ovf: cover property (event_routing_network_out[ST_OVF]);
endmodule

bind tcc_timer tcc_timer_checker u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cc_out(cc_out), .cc_out_n(cc_out_n),
  .event_routing_network_out(event_routing_network_out), .irq(irq));

// ===== tcc_far_model.sv
// far-side model: capture pins, routed event lines and count input
module tcc_far_model
  import tcc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // far-side lines
  output logic      [NUM_CH-1:0] cc_in,
  output logic      [NUM_CH-1:0] ev_in,
  output logic                   count_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] lines = 9'h000;
  assign {count_in, ev_in, cc_in} = lines;
  // pulses last 4 cycles so the two-stage synchroniser sees both edges
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      lines[sel] <= 1'b1;
      repeat (4) @(posedge clk);
      lines[sel] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the timer block
module tb_top
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, count_in, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, prdata2, rd, rd2;
  logic [NUM_CH-1:0] cc_in, ev_in, cc_out, cc_out_n, cc_out2, cc_out_n2;
  logic [ST_W-1:0]   ev_out;
  int                fails = 0;
  int                check_count = 0;
  int                n, m;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} tcc_row_t;
  tcc_row_t rows [15] = '{
    '{0, REG_CTRL, 0, 0, 0}, '{0, REG_TOP, 0, 32'h0000_FFFF, 0}, '{0, REG_STATUS, 0, 0, 0},
    '{0, REG_DTIME, 0, 0, 0}, '{1, REG_IEN, 32'h1F, 0, 0}, '{0, REG_IEN, 0, 32'h1F, 0},
    '{1, REG_CLEAR, 32'h1F, 0, 0}, '{0, REG_CLEAR, 0, 0, 0}, '{1, REG_CHCAP0, 32'hAAAA, 0, 0},
    '{0, REG_CHCAP0, 0, 0, 0}, '{1, REG_DTIME, 32'h5, 0, 0}, '{0, REG_DTIME, 0, 32'h5, 0},
    '{0, 8'h1C, 0, 0, 1}, '{0, 8'h50, 0, 0, 1}, '{1, 8'h06, 32'h1, 0, 1}};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  tcc_timer #(.HAS_DTI(1'b1)) uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc_in(cc_in), .event_routing_network_in(ev_in), .count_in(count_in),
    .cc_out(cc_out), .cc_out_n(cc_out_n), .event_routing_network_out(ev_out), .irq(irq));
  // second instance shares the bus; its read data and output pair are watched
  tcc_timer #(.HAS_DTI(1'b0)) uut2 (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(),
    .pslverr(), .cc_in(cc_in), .event_routing_network_in(ev_in), .count_in(count_in),
    .cc_out(cc_out2), .cc_out_n(cc_out_n2), .event_routing_network_out(), .irq());
  tcc_far_model far (.clk(clk), .cc_in(cc_in), .ev_in(ev_in), .count_in(count_in));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd2 = prdata2;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic r(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask

  task automatic hi_count(output int c);
    c = 0;
    repeat (20) begin
      @(negedge clk);
      c += (cc_out[3] === 1'b1);
    end
  endtask

  // cycles in which both sides of pair three are low, first and second instance
  task automatic gap_count(output int c, output int c2);
    c  = 0;
    c2 = 0;
    repeat (20) begin
      @(negedge clk);
      c  += (cc_out[3] === 1'b0 && cc_out_n[3] === 1'b0);
      c2 += (cc_out2[3] === 1'b0 && cc_out_n2[3] === 1'b0);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} <= '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("rdata", rows[i].e, rd);
      chk("slverr", {31'h0, rows[i].er}, {31'h0, er});
    end
    apb(1'b0, REG_DTIME, 32'h0);
    chk("dtime second", 0, rd2);
    w(REG_IEN, 32'h10);
    w(REG_TOP, 32'h3);
    w(REG_CTRL, 32'h1);
    n = 0;
    while (ev_out[ST_OVF] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("ovf pulse", 1, n < 20);
    repeat (2) @(negedge clk);
    chk("irq set", 1, irq);
    apb(1'b0, REG_CNT, 32'h0);
    chk("cnt range", 1, rd <= 32'h3);
    w(REG_CTRL, 32'h0);
    w(REG_CLEAR, 32'h1F);
    r("status clr", REG_STATUS, 32'h0);
    @(negedge clk);
    chk("irq clr", 0, irq);
    w(REG_IEN, 32'h0);
    w(REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    w(REG_CTRL, 32'h0);
    r("masked", REG_STATUS, 32'h10);
    chk("irq masked", 0, irq);
    w(REG_TOP, 32'hFFFF);
    w(REG_CNT, 32'hFFFE);
    w(REG_CTRL, 32'h1);
    // let the count pass the top before sampling it
    repeat (4) @(posedge clk);
    apb(1'b0, REG_CNT, 32'h0);
    chk("wrap", 1, rd < 32'h10);
    w(REG_CTRL, 32'h0);
    w(REG_CNT, 32'h0);
    w(REG_CTRL, 32'h3);
    far.pulse(8, 5);
    r("events", REG_CNT, 32'h5);
    w(REG_CTRL, 32'h0);
    w(REG_CLEAR, 32'h1F);
    w(REG_CNT, 32'h123);
    w(REG_CHCFG0, 32'h01);
    far.pulse(0, 1);
    r("cap0", REG_CHCAP0, 32'h123);
    w(8'h28, 32'h11);
    far.pulse(6, 1);
    r("cap2", 8'h48, 32'h123);
    r("cap flags", REG_STATUS, 32'h05);
    w(8'h24, 32'h02);
    w(8'h34, 32'h10);
    w(REG_CNT, 32'h8);
    repeat (4) @(negedge clk);
    chk("cmp low", 0, cc_out[1]);
    w(REG_CNT, 32'h20);
    repeat (4) @(negedge clk);
    chk("cmp high", 1, cc_out[1]);
    chk("cmp comp", 0, cc_out_n[1]);
    w(REG_CNT, 32'h0);
    w(REG_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    w(REG_CTRL, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("match flag", 1, rd[1]);
    w(REG_TOP, 32'h9);
    w(8'h2C, 32'h03);
    w(8'h3C, 32'h5);
    w(REG_CNT, 32'h0);
    w(REG_CTRL, 32'h1);
    repeat (15) @(posedge clk);
    hi_count(n);
    chk("pwm high 5", 10, n);
    w(8'h3C, 32'h2);
    repeat (15) @(posedge clk);
    hi_count(n);
    chk("pwm high 2", 4, n);
    r("pwm val", 8'h3C, 32'h2);
    // dead time of two: each change blanks the pair for three cycles, merged per period
    w(REG_DTIME, 32'h2);
    w(REG_CTRL, 32'h5);
    repeat (15) @(posedge clk);
    gap_count(n, m);
    chk("dead gap", 10, n);
    chk("no gap second", 0, m);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(negedge clk);
    chk("rst out", 0, {cc_out, irq});
    @(posedge clk);
    nrst <= 1'b1;
    r("rst top", REG_TOP, 32'h0000_FFFF);
    results();
  end
endmodule
